//--- rtl/ctt_pkg.sv
// Package with register map, field positions and timing constants.
package ctt_pkg;
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned TS_US_NS      = 1000;
   localparam int unsigned CLK_NS        = 10;
   localparam int unsigned US_CYCLES     = TS_US_NS / CLK_NS;
   localparam int unsigned ADDR_W        = 4;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned TS_W          = 32;
   localparam int unsigned CNT_W         = 32;
   // Register offsets.
   localparam logic [3:0] OFF_CTRL       = 4'h0;
   localparam logic [3:0] OFF_PERIOD     = 4'h4;
   localparam logic [3:0] OFF_WIDTH      = 4'h8;
   localparam logic [3:0] OFF_TS         = 4'hC;
   // Extra registers at the unused low offsets 1 and 2 are decoded by index.
   localparam logic [3:0] OFF_STAMP      = 4'h1;
   localparam logic [3:0] OFF_STATUS     = 4'h2;
   // Control fields.
   localparam int unsigned CTRL_EN1      = 0;
   localparam int unsigned CTRL_EN2      = 1;
   localparam int unsigned CTRL_SYNC     = 2;
   localparam int unsigned CTRL_SRC      = 3;
   // Reset values.
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0] PERIOD_RST    = 32'h0000_03E8;
   localparam logic [31:0] WIDTH_RST     = 32'h0000_0064;
endpackage

//--- rtl/ctt_pulse_gen.sv
// Periodic trigger pulse generator with period-boundary reload.
`timescale 1ns/100ps
module ctt_pulse_gen #(
   parameter int unsigned CNT_W = 32
) (
   // Clock and reset.
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   // Settings in microseconds.
   input  wire logic             enable,
   input  wire logic [CNT_W-1:0] period_us,
   input  wire logic [CNT_W-1:0] width_us,
   input  wire logic             us_tick,
   // Output.
   output logic                  trig,
   output logic                  start
);
   import ctt_pkg::*;

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] per;
   logic [CNT_W-1:0] wid;
   logic             run;

   // Count microseconds and reload settings at each period start.
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !enable) begin
         cnt <= '0;
         run <= 1'b0;
         per <= '0;
         wid <= '0;
      end else if (!run || (us_tick && cnt + 1'b1 >= per)) begin
         cnt <= '0;
         run <= 1'b1;
         per <= (period_us == '0) ? CNT_W'(1) : period_us;
         wid <= width_us;
      end else if (us_tick) begin
         cnt <= cnt + 1'b1;
      end
   end

   // Period start strobe for the stamp logic.
   assign start = enable && (!run || (us_tick && cnt + 1'b1 >= per));

   // High while inside the pulse, low when disabled.
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !enable) begin
         trig <= 1'b0;
      end else begin
         trig <= run && (cnt < wid) && !start;
      end
   end

   // A disabled generator keeps its output low.
   property p_low_off;
      @(posedge sys_clk) disable iff (sys_rst)
      !enable |=> !trig;
   endproperty
   a_low_off: assert property (p_low_off)
      else $error("trigger high while disabled");
   // The registered pulse only follows a cycle inside the programmed width.
   property p_width;
      @(posedge sys_clk) disable iff (sys_rst)
      trig |-> $past(run && (cnt < wid));
   endproperty
   a_width: assert property (p_width)
      else $error("trigger outside programmed width");
endmodule

//--- rtl/ctt_edge_sync.sv
// Two-flop synchroniser with rising-edge detector.
`timescale 1ns/100ps
module ctt_edge_sync (
   // Clock and reset.
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // Pin input and detected edge.
   input  wire logic pin_in,
   output logic      rise
);
   logic meta;
   logic sync;
   logic last;

   // Meta flop feeds only the second flop.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= pin_in;
         sync <= meta;
         last <= sync;
      end
   end

   // One-cycle pulse on a rising level.
   assign rise = sync && !last;
endmodule

//--- rtl/ctt_top.sv
// Camera trigger generator with microsecond timestamp counter.
`timescale 1ns/100ps
module ctt_top (
   // Clock and reset.
   input  wire logic                       sys_clk,
   input  wire logic                       sys_rst,
   // Register port.
   input  wire logic [ctt_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [ctt_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [ctt_pkg::DATA_W-1:0] reg_rdata,
   // Frame arrival strobe from capture logic.
   input  wire logic                       frame_in,
   // Frame done strobe, ends the pending stamp.
   input  wire logic                       frame_out,
   // Trigger pin 1 is two-way, pin 2 output only.
   input  wire logic                       trig1_i,
   output logic                            trig1_o,
   output logic                            trig1_oe,
   output logic                            trig2_o,
   // Stamp for the current frame.
   output logic      [ctt_pkg::TS_W-1:0]   frame_stamp
);
   import ctt_pkg::*;

   logic [31:0]        ctrl;
   logic [31:0]        period;
   logic [31:0]        width;
   logic [6:0]         div;
   logic               us_tick;
   logic [TS_W-1:0]    ts;
   logic               sync_rise;
   logic               pend;
   logic               neg;
   logic               trig1_raw;
   logic               start1;
   logic               start2;
   logic               trig2_raw;
   logic               take;
   logic               sync_on;

   assign sync_on = ctrl[CTRL_SYNC];

   // Control registers written by software.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrl   <= CTRL_RST;
         period <= PERIOD_RST;
         width  <= WIDTH_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            OFF_CTRL:   ctrl   <= {28'h000_0000, reg_wdata[3:0]};
            OFF_PERIOD: period <= reg_wdata;
            OFF_WIDTH:  width  <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   // Microsecond prescaler.
   always_ff @(posedge sys_clk) begin
      if (sys_rst || (sync_on && sync_rise)) begin
         div <= '0;
      end else if (div == 7'(US_CYCLES - 1)) begin
         div <= '0;
      end else begin
         div <= div + 7'd1;
      end
   end
   assign us_tick = (div == 7'(US_CYCLES - 1));

   // Timestamp counter, zero at reset, cleared by sync edges.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ts <= '0;
      end else if (sync_on && sync_rise) begin
         ts <= '0;
      end else if (us_tick) begin
         ts <= ts + 1'b1;
      end
   end

   // Synchronise the shared pin input.
   ctt_edge_sync u_sync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pin_in  (trig1_i),
      .rise    (sync_rise)
   );

   // Trigger generators; channel 1 disabled in sync mode.
   ctt_pulse_gen #(.CNT_W(CNT_W)) u_gen1 (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .enable    (ctrl[CTRL_EN1] && !sync_on),
      .period_us (period),
      .width_us  (width),
      .us_tick   (us_tick),
      .trig      (trig1_raw),
      .start     (start1)
   );

   ctt_pulse_gen #(.CNT_W(CNT_W)) u_gen2 (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .enable    (ctrl[CTRL_EN2]),
      .period_us (period),
      .width_us  (width),
      .us_tick   (us_tick),
      .trig      (trig2_raw),
      .start     (start2)
   );

   // Pin drivers, pin 1 released when used as input.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         trig1_o  <= 1'b0;
         trig1_oe <= 1'b1;
         trig2_o  <= 1'b0;
      end else begin
         trig1_o  <= trig1_raw && !sync_on;
         trig1_oe <= !sync_on;
         trig2_o  <= trig2_raw;
      end
   end

   // Stamp source: trigger start or frame arrival.
   assign take = ctrl[CTRL_SRC] ? frame_in : (start1 || start2);

   // Latch stamp; a sync edge while pending makes it negative.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         frame_stamp <= '0;
         pend        <= 1'b0;
         neg         <= 1'b0;
      end else if (take) begin
         frame_stamp <= ts;
         pend        <= 1'b1;
         neg         <= 1'b0;
      end else if (pend && sync_on && sync_rise && !neg) begin
         frame_stamp <= frame_stamp - ts
                        - TS_W'(us_tick ? 1 : 0);
         neg         <= 1'b1;
      end else if (frame_out) begin
         pend <= 1'b0;
      end
   end

   // Read data, one cycle after the strobe.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            OFF_CTRL:   reg_rdata <= ctrl;
            OFF_PERIOD: reg_rdata <= period;
            OFF_WIDTH:  reg_rdata <= width;
            OFF_TS:     reg_rdata <= ts;
            OFF_STAMP:  reg_rdata <= frame_stamp;
            OFF_STATUS: reg_rdata <= {28'h000_0000, neg, pend,
                                      trig2_o, trig1_o};
            default:    reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // A sync edge clears the timestamp on the next cycle.
   property p_sync_clear;
      @(posedge sys_clk) disable iff (sys_rst)
      sync_on && sync_rise |=> ts == '0;
   endproperty
   a_sync_clear: assert property (p_sync_clear)
      else $error("timestamp not cleared by sync edge");

   // In sync mode pin 1 is released and its output held low.
   property p_pin_release;
      @(posedge sys_clk) disable iff (sys_rst)
      sync_on |=> !trig1_oe && !trig1_o;
   endproperty
   a_pin_release: assert property (p_pin_release)
      else $error("pin 1 still driven in sync mode");

   // Outside sync mode the module drives pin 1.
   property p_oe_normal;
      @(posedge sys_clk) disable iff (sys_rst)
      !sync_on |=> trig1_oe;
   endproperty
   a_oe_normal: assert property (p_oe_normal)
      else $error("pin 1 released outside sync mode");

   // Without a tick or a sync edge the timestamp holds.
   property p_ts_step;
      @(posedge sys_clk) disable iff (sys_rst)
      !(sync_on && sync_rise) && !us_tick |=> ts == $past(ts);
   endproperty
   a_ts_step: assert property (p_ts_step)
      else $error("timestamp moved without tick");

   // Each microsecond tick advances the timestamp by one.
   property p_ts_inc;
      @(posedge sys_clk) disable iff (sys_rst)
      !(sync_on && sync_rise) && us_tick |=> ts == $past(ts) + 1;
   endproperty
   a_ts_inc: assert property (p_ts_inc)
      else $error("timestamp failed to count");

   // The microsecond tick is a single-cycle strobe.
   property p_tick_once;
      @(posedge sys_clk) disable iff (sys_rst)
      us_tick |=> !us_tick;
   endproperty
   a_tick_once: assert property (p_tick_once)
      else $error("microsecond tick longer than one cycle");

   // Reset leaves the timestamp at zero.
   property p_reset_zero;
      @(posedge sys_clk)
      sys_rst |=> ts == '0;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("timestamp not zero after reset");

   // A sync edge while a stamp is pending flags it negative.
   property p_neg;
      @(posedge sys_clk) disable iff (sys_rst)
      !take && pend && sync_on && sync_rise && !neg |=> neg;
   endproperty
   a_neg: assert property (p_neg)
      else $error("negative stamp not flagged");

   // The negative stamp plus the elapsed count gives the old stamp.
   property p_neg_value;
      @(posedge sys_clk) disable iff (sys_rst)
      !take && pend && sync_on && sync_rise && !neg
      |=> frame_stamp + $past(ts) + TS_W'($past(us_tick))
          == $past(frame_stamp);
   endproperty
   a_neg_value: assert property (p_neg_value)
      else $error("negative stamp offset wrong");

   // Frame done ends the pending window.
   property p_pend_clear;
      @(posedge sys_clk) disable iff (sys_rst)
      frame_out && !take && !(sync_on && sync_rise) |=> !pend;
   endproperty
   a_pend_clear: assert property (p_pend_clear)
      else $error("pending stamp not ended by frame done");

   // Trigger 2 stays low while its channel is off.
   property p_off2;
      @(posedge sys_clk) disable iff (sys_rst)
      !ctrl[CTRL_EN2] ##1 !ctrl[CTRL_EN2] |=> !trig2_o;
   endproperty
   a_off2: assert property (p_off2)
      else $error("trigger 2 high while disabled");

   // A stamp request latches the current timestamp.
   property p_take;
      @(posedge sys_clk) disable iff (sys_rst)
      take |=> frame_stamp == $past(ts) && pend;
   endproperty
   a_take: assert property (p_take)
      else $error("stamp not latched");

   // Read data return to zero when no read is made.
   property p_rdata_idle;
      @(posedge sys_clk) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == '0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read cycle");

   // A timestamp read returns the count of the strobe cycle.
   property p_rd_ts;
      @(posedge sys_clk) disable iff (sys_rst)
      reg_rd && reg_addr == OFF_TS |=> reg_rdata == $past(ts);
   endproperty
   a_rd_ts: assert property (p_rd_ts)
      else $error("timestamp read wrong");

   // A control write lands in the low control bits.
   property p_ctrl_wr;
      @(posedge sys_clk) disable iff (sys_rst)
      reg_wr && reg_addr == OFF_CTRL
      |=> ctrl[3:0] == $past(reg_wdata[3:0]);
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr)
      else $error("control write lost");

   // A period write lands unchanged.
   property p_period_wr;
      @(posedge sys_clk) disable iff (sys_rst)
      reg_wr && reg_addr == OFF_PERIOD |=> period == $past(reg_wdata);
   endproperty
   a_period_wr: assert property (p_period_wr)
      else $error("period write lost");

endmodule

//--- testbench/ctt_partner.sv
// Camera trigger inputs and pulse-per-second source model.
`timescale 1ns/100ps
module ctt_partner (
   // Clock.
   input  wire logic        sys_clk,
   // Trigger lines seen by the cameras.
   input  wire logic        trig1_o,
   input  wire logic        trig1_oe,
   input  wire logic        trig2_o,
   // Sync pulse request and pin drive.
   input  wire logic        pps_go,
   output logic             pps_drv,
   // Trigger 2 high time and period in clock cycles, and rising-edge counts of both lines.
   output logic [31:0]      hi_len,
   output logic [31:0]      per_len,
   output logic [31:0]      n1,
   output logic [31:0]      n2
);
   logic [31:0] hcnt = '0;
   logic [31:0] pcnt = '0;
   logic [7:0]  pps_cnt = '0;
   logic        t1_d = 1'b0;
   logic        t2_d = 1'b0;
   initial {hi_len, per_len, n1, n2} = '0;
   // Cameras may expose on either edge, so both edges are timed.
   always @(posedge sys_clk) begin
      t1_d <= trig1_o;
      t2_d <= trig2_o;
      pcnt <= pcnt + 1;
      if (trig2_o) hcnt <= hcnt + 1;
      if (trig2_o && !t2_d) begin
         per_len <= pcnt;
         pcnt    <= 32'h0000_0001;
         hcnt    <= 32'h0000_0001;
         n2      <= n2 + 1;
      end
      if (!trig2_o && t2_d) hi_len <= hcnt;
      if (trig1_o && !t1_d && trig1_oe) n1 <= n1 + 1;
   end
   // One rising edge per request, then the model drives the line low again after 50 cycles.
   always @(posedge sys_clk) begin
      if (pps_go) pps_cnt <= 8'h32;
      else if (pps_cnt != 0) pps_cnt <= pps_cnt - 1;
   end
   assign pps_drv = (pps_cnt != 0);
endmodule

//--- testbench/ctt_top_test.sv
// Self-checking testbench for the camera trigger timebase.
`timescale 1ns/100ps
module ctt_top_test;
   import ctt_pkg::*;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [3:0]  reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        rd_d = 1'b0;
   logic        pps_go = 1'b0;
   logic        frame_in = 1'b0;
   logic        frame_out = 1'b0;
   logic [31:0] reg_rdata, frame_stamp, hi_len, per_len, n1, n2;
   logic        trig1_o, trig1_oe, trig2_o, pps_drv;
   wire         pin = trig1_oe ? trig1_o : pps_drv;
   int          err_total = 0;
   int          check_count = 0;
   int          seed = 32'hbf614704;
   logic [31:0] exp_q[$];
   logic [31:0] p, w, k;
   always #5 sys_clk = ~sys_clk;
   ctt_top ctt_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_in(frame_in),
      .frame_out(frame_out), .trig1_i(pin), .trig1_o(trig1_o),
      .trig1_oe(trig1_oe), .trig2_o(trig2_o), .frame_stamp(frame_stamp));
   ctt_partner ctt_partner_i (.sys_clk(sys_clk), .trig1_o(trig1_o),
      .trig1_oe(trig1_oe), .trig2_o(trig2_o), .pps_go(pps_go),
      .pps_drv(pps_drv), .hi_len(hi_len), .per_len(per_len), .n1(n1),
      .n2(n2));
   // Compares one value and counts the outcome.
   task check(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Compares within a tolerance of a few cycles.
   task near(input logic [31:0] s, input logic [31:0] e, input int t);
      check(32'((s > e ? s - e : e - s) <= t), 32'h0000_0001);
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Issues a read and leaves the expected word for the monitor.
   task rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
   endtask
   task wait_rises(input int n);
      k = n2 + n;
      for (int i = 0; i < 20000 && n2 < k; i++) @(posedge sys_clk);
      check(32'(n2 >= k), 32'h0000_0001);
   endtask
   // Requests one sync edge from the partner model.
   task pps;
      pps_go <= 1'b1;
      @(posedge sys_clk);
      pps_go <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Read data stand only in the cycle after the strobe.
   always @(posedge sys_clk) begin
      if (rd_d) check(reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd;
   end
   task complete_run;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_total++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rd(OFF_TS, 32'h0000_0000);
      rd(OFF_CTRL, CTRL_RST);
      rd(OFF_PERIOD, PERIOD_RST);
      rd(OFF_WIDTH, WIDTH_RST);
      rd(4'h5, 32'h0000_0000);
      check({31'h0, trig1_oe}, 32'h0000_0001);
      check({30'h0, trig1_o, trig2_o}, 32'h0000_0000);
      // Trigger 2 alone at several random widths and periods.
      for (int j = 0; j < 3; j++) begin
         p = 32'(3 + ($random(seed) & 3));
         w = 32'(1 + ($random(seed) & 1));
         wr(OFF_PERIOD, p);
         wr(OFF_WIDTH, w);
         wr(OFF_CTRL, 32'h0000_0002);
         rd(OFF_PERIOD, p);
         wait_rises(3);
         near(per_len, p * US_CYCLES, 1);
         near(hi_len, w * US_CYCLES, 2);
      end
      check(n1, 32'h0000_0000);
      // Both channels together; trigger 1 pulses on its pin too.
      wr(OFF_CTRL, 32'h0000_0003);
      wait_rises(3);
      check(32'(n1 >= 2), 32'h0000_0001);
      // Sync mode frees pin 1 and clears the timestamp on its edge.
      wr(OFF_CTRL, 32'h0000_0006);
      repeat (5) @(posedge sys_clk);
      check({31'h0, trig1_oe}, 32'h0000_0000);
      pps();
      repeat (12) @(posedge sys_clk);
      rd(OFF_TS, 32'h0000_0000);
      wait_rises(2);
      near(per_len, p * US_CYCLES, 1);
      // Frame-arrival stamps; a sync edge while pending goes negative.
      wr(OFF_CTRL, 32'h0000_000C);
      pps();
      repeat (700) @(posedge sys_clk);
      frame_in <= 1'b1;
      @(posedge sys_clk);
      frame_in <= 1'b0;
      repeat (300) @(posedge sys_clk);
      near(frame_stamp, 32'h0000_0007, 1);
      rd(OFF_STATUS, 32'h0000_0004);
      pps();
      repeat (12) @(posedge sys_clk);
      near(32'h0000_0000 - frame_stamp, 32'h0000_0003, 1);
      rd(OFF_STATUS, 32'h0000_000C);
      frame_out <= 1'b1;
      @(posedge sys_clk);
      frame_out <= 1'b0;
      rd(OFF_STATUS, 32'h0000_0008);
      // Both outputs off stay low.
      wr(OFF_CTRL, 32'h0000_0000);
      repeat (1000) @(posedge sys_clk);
      check({30'h0, trig1_o, trig2_o}, 32'h0000_0000);
      repeat (4) @(posedge sys_clk);
      complete_run();
   end
endmodule
